// ### rcss_reclose_supervisor.sv
// Reclose event masking, fault code encoding and self-supervision sequencer.
// Assumes synchronous fault and event inputs and an Avalon-MM master.
// What this block does
// - First mask holds twelve enable bits, weights 1 to 2048.
// - Shot start/end events use weights 1-32; breaker open 64, closed 128; on.
// - Definite-trip alarm set at 256, reset at 512, both enabled by default.
// - Lockout set at 1024, reset at 2048, both disabled by default.
// - Second mask: open command 1,2; close command 4,8; all disabled.
// - Reclosing failed 16,32 and reclosing disabled 64,128, all enabled.
// - Cancelled set/reset at 256,512 enabled; second mask default 1008.
// - An internal fault first triggers a restart; declared only if it persists.
// - Declared fault flashes ready, raises supervision output, shows coded message.
// - While declared, all other output contacts are forced idle and locked.
// - Internal-fault target has top panel priority over all other targets.
// - Clearing the fault target is ignored while ready is flashing.
// - Fault gone ends flashing and resumes service; message latched until cleared.
// - Base contact faults coded 4-8, enable path 9, feedback 10-12.
// - Optional contact faults coded 13-15, enable path 16, feedback 17-19.
// - Supply dip 20/21, program memory 30, work memory 50/59.
// - Parameter memory 51-54/56, calibration 55; settings read zero during it.
// - I/O module missing 80, unknown 81, config 82; power 85 faulty, 86 unknown.
// - Hardware configuration error 90, unknown communication module 95.
// - Light sensor two 240, one 241; measuring unit 253.
// - Reference voltage error reported with one of 131,139,195,203,222,223.
//
// The address map and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
module rcss_reclose_supervisor #(
    parameter int RECOVER_CYC = rcss_pkg::RCSS_RECOVER_CYC,
    parameter int FLASH_CYC = rcss_pkg::RCSS_FLASH_CYC,
    parameter int NUM_CONTACTS = 8
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Avalon-MM register slave.
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Reclose and breaker event pulses, one bit per event.
    input wire logic [rcss_pkg::RCSS_LOW_W-1:0] evt_low,
    input wire logic [rcss_pkg::RCSS_HIGH_W-1:0] evt_high,
    // Fault sources.
    input wire logic [4:0] flt_base_contact,
    input wire logic flt_base_enable,
    input wire logic flt_base_feedback,
    input wire logic [2:0] flt_opt_contact,
    input wire logic flt_opt_enable,
    input wire logic flt_opt_feedback,
    input wire logic flt_supply_dip,
    input wire logic flt_program_mem,
    input wire logic flt_work_mem,
    input wire logic flt_param_mem,
    input wire logic flt_calib_mem,
    input wire logic [2:0] flt_io_module,
    input wire logic [1:0] flt_power_module,
    input wire logic flt_hw_config,
    input wire logic flt_comm_unknown,
    input wire logic flt_vref,
    input wire logic [1:0] flt_light_sensor,
    input wire logic flt_measure,
    // Contact requests from protection logic and panel targets.
    input wire logic [NUM_CONTACTS-1:0] contact_req,
    input wire logic [7:0] panel_target_req,
    input wire logic panel_clear,
    // Outputs to contacts, panel and restart logic.
    output logic [NUM_CONTACTS-1:0] contact_out,
    output logic supervision_out,
    output logic ready_led,
    output logic restart_req,
    output logic [7:0] panel_code,
    output logic panel_fault_shown,
    output logic [7:0] panel_target
);
    import rcss_pkg::*;

    // Refuse sizes that the contact and counter logic cannot serve.
    if (NUM_CONTACTS < 1 || NUM_CONTACTS > 16
            || RECOVER_CYC < 1 || FLASH_CYC < 1) begin : g_param_check
        $error("rcss_reclose_supervisor: parameter out of range");
    end

    localparam int CNT_W = 32;
    localparam logic [CNT_W-1:0] RESTART_LEN = CNT_W'(RCSS_RESTART_CYC);
    localparam logic [CNT_W-1:0] RECOVER_LEN = CNT_W'(RECOVER_CYC);
    localparam logic [CNT_W-1:0] FLASH_LEN = CNT_W'(FLASH_CYC);

    typedef struct packed {
        logic [RCSS_LOW_W-1:0] mask_low;
        logic [RCSS_HIGH_W-1:0] mask_high;
        logic [RCSS_LOW_W-1:0] seen_low;
        logic [RCSS_HIGH_W-1:0] seen_high;
        logic [RCSS_LOW_W-1:0] rep_low;
        logic [RCSS_HIGH_W-1:0] rep_high;
        rcss_state_t state;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] flash_cnt;
        logic flash_phase;
        logic msg_latched;
        logic [7:0] code;
        logic [31:0] rdata;
        logic ack;
        logic [NUM_CONTACTS-1:0] contacts;
        logic sup;
        logic led;
        logic restart;
        logic [7:0] target;
    } rcss_regs_t;

    rcss_regs_t cur_ff;
    rcss_regs_t nxt_ff;

    logic any_fault;
    logic [7:0] fault_code;
    logic wr_hit;
    logic rd_hit;
    logic flashing;

    // Encode the highest-priority active fault into its code.
    // Only one code can be shown, so the most serious fault class is chosen.
    always_comb begin
        fault_code = RCSS_CODE_NONE;
        if (flt_measure) fault_code = RCSS_CODE_MEASURE;
        else if (flt_light_sensor[0]) fault_code = RCSS_CODE_LIGHT_ONE;
        else if (flt_light_sensor[1]) fault_code = RCSS_CODE_LIGHT_TWO;
        else if (flt_vref) fault_code = RCSS_CODE_VREF;
        else if (flt_comm_unknown) fault_code = RCSS_CODE_COMM_UNKNOWN;
        else if (flt_hw_config) fault_code = RCSS_CODE_HW_CONFIG;
        else if (flt_power_module[0]) fault_code = RCSS_CODE_POWER_FAULTY;
        else if (flt_power_module[1]) fault_code = RCSS_CODE_POWER_UNKNOWN;
        else if (flt_io_module[0]) fault_code = RCSS_CODE_IO_MISSING;
        else if (flt_io_module[1]) fault_code = RCSS_CODE_IO_UNKNOWN;
        else if (flt_io_module[2]) fault_code = RCSS_CODE_IO_CONFIG;
        else if (flt_calib_mem) fault_code = RCSS_CODE_CALIB_MEM;
        else if (flt_param_mem) fault_code = RCSS_CODE_PARAM_MEM;
        else if (flt_work_mem) fault_code = RCSS_CODE_WORK_MEM;
        else if (flt_program_mem) fault_code = RCSS_CODE_PROGRAM_MEM;
        else if (flt_supply_dip) fault_code = RCSS_CODE_SUPPLY_DIP;
        else if (flt_opt_feedback) fault_code = RCSS_CODE_OPT_FEEDBACK;
        else if (flt_opt_enable) fault_code = RCSS_CODE_OPT_ENABLE;
        else if (|flt_opt_contact) begin
            for (int i = 2; i >= 0; i--) begin
                if (flt_opt_contact[i]) fault_code = RCSS_CODE_OPT_CONTACT0 + 8'(i);
            end
        end else if (flt_base_feedback) fault_code = RCSS_CODE_BASE_FEEDBACK;
        else if (flt_base_enable) fault_code = RCSS_CODE_BASE_ENABLE;
        else if (|flt_base_contact) begin
            for (int i = 4; i >= 0; i--) begin
                if (flt_base_contact[i]) fault_code = RCSS_CODE_BASE_CONTACT0 + 8'(i);
            end
        end
    end

    assign any_fault = (fault_code != RCSS_CODE_NONE);
    assign flashing = (cur_ff.state == RCSS_ST_FAULT);
    // One-cycle answer: waitrequest is low when the access is being acknowledged.
    // Writes land at the acknowledge edge, the one at which the master sees
    // waitrequest low; read data is registered one edge earlier so that it
    // stands in the acknowledge cycle.
    assign wr_hit = avs_write && cur_ff.ack;
    assign rd_hit = avs_read && !cur_ff.ack;

    // Next-state logic for registers, events and supervision sequencer.
    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.ack = (avs_read || avs_write) && !cur_ff.ack;
        nxt_ff.restart = 1'b0;

        // Software writes to the masks and control word.
        if (wr_hit && avs_byteenable[0]) begin
            unique case (avs_address)
                RCSS_ADDR_MASK_LOW: nxt_ff.mask_low[7:0] = avs_writedata[7:0];
                RCSS_ADDR_MASK_HIGH: nxt_ff.mask_high[7:0] = avs_writedata[7:0];
                default: ;
            endcase
        end
        if (wr_hit && avs_byteenable[1]) begin
            unique case (avs_address)
                RCSS_ADDR_MASK_LOW: nxt_ff.mask_low[11:8] = avs_writedata[11:8];
                RCSS_ADDR_MASK_HIGH: nxt_ff.mask_high[9:8] = avs_writedata[9:8];
                default: ;
            endcase
        end

        // All events are seen; only enabled ones are reported. Set beats clear.
        nxt_ff.seen_low = cur_ff.seen_low | evt_low;
        nxt_ff.seen_high = cur_ff.seen_high | evt_high;
        if (wr_hit && avs_address == RCSS_ADDR_CONTROL && avs_writedata[RCSS_CTL_CLEAR_EVT]) begin
            nxt_ff.rep_low = evt_low & cur_ff.mask_low;
            nxt_ff.rep_high = evt_high & cur_ff.mask_high;
            nxt_ff.seen_low = evt_low;
            nxt_ff.seen_high = evt_high;
        end else begin
            nxt_ff.rep_low = cur_ff.rep_low | (evt_low & cur_ff.mask_low);
            nxt_ff.rep_high = cur_ff.rep_high | (evt_high & cur_ff.mask_high);
        end

        // Supervision sequencer: restart, verify, then declare.
        // A restart that clears the fault returns to service with no declaration.
        unique case (cur_ff.state)
            RCSS_ST_OK: begin
                if (any_fault) begin
                    nxt_ff.state = RCSS_ST_RESTART;
                    nxt_ff.cnt = RESTART_LEN;
                end
            end
            RCSS_ST_RESTART: begin
                nxt_ff.restart = 1'b1;
                nxt_ff.cnt = cur_ff.cnt - 1'b1;
                if (cur_ff.cnt == 1) begin
                    nxt_ff.state = RCSS_ST_VERIFY;
                    nxt_ff.cnt = RECOVER_LEN;
                end
            end
            RCSS_ST_VERIFY: begin
                nxt_ff.cnt = cur_ff.cnt - 1'b1;
                if (!any_fault) begin
                    nxt_ff.state = RCSS_ST_OK;
                end else if (cur_ff.cnt == 1) begin
                    nxt_ff.state = RCSS_ST_FAULT;
                    nxt_ff.msg_latched = 1'b1;
                    nxt_ff.code = fault_code;
                    nxt_ff.flash_cnt = FLASH_LEN;
                end
            end
            RCSS_ST_FAULT: begin
                if (!any_fault) begin
                    nxt_ff.state = RCSS_ST_OK;
                end
            end
        endcase

        // Ready indicator flashes while the fault is declared.
        // The half-period counter reloads itself, so the rhythm stays fixed.
        if (nxt_ff.state == RCSS_ST_FAULT) begin
            nxt_ff.flash_cnt = (cur_ff.flash_cnt <= 1) ? FLASH_LEN : cur_ff.flash_cnt - 1'b1;
            if (cur_ff.flash_cnt <= 1) nxt_ff.flash_phase = !cur_ff.flash_phase;
            nxt_ff.led = cur_ff.flash_phase;
        end else begin
            nxt_ff.flash_phase = 1'b0;
            nxt_ff.led = 1'b1;
        end

        // Clear of the message is refused while flashing.
        // It is also refused while any fault is present, so the operator cannot
        // lose the code of a fault that is still being verified.
        if ((panel_clear || (wr_hit && avs_address == RCSS_ADDR_CONTROL
                && avs_writedata[RCSS_CTL_CLEAR_MSG])) && !flashing && !any_fault) begin
            nxt_ff.msg_latched = 1'b0;
        end

        // Supervision, contact locking and target choice follow the next state,
        // so they all change at the same edge as the sequencer.
        nxt_ff.sup = (nxt_ff.state == RCSS_ST_FAULT);
        nxt_ff.contacts = (nxt_ff.state == RCSS_ST_FAULT) ? '0 : contact_req;
        nxt_ff.target = nxt_ff.msg_latched ? nxt_ff.code : panel_target_req;

        // Read data; settings read as zero during a parameter memory fault.
        nxt_ff.rdata = '0;
        if (rd_hit) begin
            unique case (avs_address)
                RCSS_ADDR_MASK_LOW: nxt_ff.rdata = flt_param_mem ? '0 : 32'(cur_ff.mask_low);
                RCSS_ADDR_MASK_HIGH: nxt_ff.rdata = flt_param_mem ? '0 : 32'(cur_ff.mask_high);
                RCSS_ADDR_STATUS: nxt_ff.rdata = {16'h0000, cur_ff.code, 3'b000,
                    cur_ff.msg_latched, cur_ff.state};
                RCSS_ADDR_CONTROL: nxt_ff.rdata = 32'({cur_ff.rep_high, cur_ff.rep_low});
                default: nxt_ff.rdata = '0;
            endcase
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            // Masks return to their enable defaults and the ready light is steady.
            cur_ff <= '0;
            cur_ff.mask_low <= RCSS_MASK_LOW_RST;
            cur_ff.mask_high <= RCSS_MASK_HIGH_RST;
            cur_ff.state <= RCSS_ST_OK;
            cur_ff.led <= 1'b1;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign avs_readdata = cur_ff.rdata;
    assign avs_waitrequest = !cur_ff.ack;
    assign contact_out = cur_ff.contacts;
    assign supervision_out = cur_ff.sup;
    assign ready_led = cur_ff.led;
    assign restart_req = cur_ff.restart;
    assign panel_code = cur_ff.code;
    assign panel_fault_shown = cur_ff.msg_latched;
    assign panel_target = cur_ff.target;

    // Contacts stay idle while the fault is declared.
    contacts_locked_a: assert property (@(posedge sys_clk) disable iff (rst)
        supervision_out |-> contact_out == '0)
        else $error("contact driven during declared fault");
    // A fault never reaches declaration without a restart first.
    restart_first_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(supervision_out) |-> $past(cur_ff.state) == RCSS_ST_VERIFY)
        else $error("fault declared without restart");
    // Declared fault latches message and code.
    fault_message_a: assert property (@(posedge sys_clk) disable iff (rst)
        supervision_out |-> panel_fault_shown && panel_code != RCSS_CODE_NONE)
        else $error("declared fault without message");
    // Fault target wins over panel targets.
    target_priority_a: assert property (@(posedge sys_clk) disable iff (rst)
        panel_fault_shown |-> panel_target == panel_code)
        else $error("fault target overridden");
    // Message cannot clear while flashing.
    clear_refused_a: assert property (@(posedge sys_clk) disable iff (rst)
        flashing && panel_fault_shown |=> panel_fault_shown)
        else $error("fault message cleared while flashing");
    // Leaving the fault restores a steady ready light.
    flash_stops_a: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(supervision_out) |-> ready_led && panel_fault_shown)
        else $error("ready not steady after fault");
    // Masked events never appear in the report.
    mask_gates_a: assert property (@(posedge sys_clk) disable iff (rst)
        (evt_low & ~cur_ff.mask_low) != '0 |=> (cur_ff.rep_low & ~$past(cur_ff.mask_low)
        & $past(evt_low)) == '0 || $past(wr_hit))
        else $error("masked event reported");
    // Every bus access gets its answer the next cycle.
    bus_answer_a: assert property (@(posedge sys_clk) disable iff (rst)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    // Every event is remembered internally, enabled or not.
    events_seen_a: assert property (@(posedge sys_clk) disable iff (rst)
        evt_low != '0 |=> (cur_ff.seen_low & $past(evt_low)) == $past(evt_low))
        else $error("event not recorded internally");
    // An enabled event of the first mask reaches the report at the next edge.
    report_low_a: assert property (@(posedge sys_clk) disable iff (rst)
        (evt_low & cur_ff.mask_low) != '0 |=> (cur_ff.rep_low
        & $past(evt_low & cur_ff.mask_low)) == $past(evt_low & cur_ff.mask_low))
        else $error("enabled event missing from report");
    // An enabled event of the second mask reaches the report at the next edge.
    report_high_a: assert property (@(posedge sys_clk) disable iff (rst)
        (evt_high & cur_ff.mask_high) != '0 |=> (cur_ff.rep_high
        & $past(evt_high & cur_ff.mask_high)) == $past(evt_high & cur_ff.mask_high))
        else $error("enabled event missing from report");
    // The ready light is steady whenever no fault is declared.
    ready_steady_a: assert property (@(posedge sys_clk) disable iff (rst)
        !supervision_out |-> ready_led)
        else $error("ready light not steady");
    // A restart runs before any declaration, with the light still steady.
    restart_clean_a: assert property (@(posedge sys_clk) disable iff (rst)
        restart_req |-> !supervision_out && ready_led)
        else $error("restart during declared fault");
    // Settings read as zero while the parameter memory is faulty.
    settings_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
        rd_hit && flt_param_mem && (avs_address == RCSS_ADDR_MASK_LOW
        || avs_address == RCSS_ADDR_MASK_HIGH) |=> avs_readdata == '0)
        else $error("setting readable during parameter fault");
    // The declared code holds while the fault stays declared.
    code_stable_a: assert property (@(posedge sys_clk) disable iff (rst)
        supervision_out && $past(supervision_out) |-> $stable(panel_code))
        else $error("fault code changed while declared");
    // Outside a declared fault the contacts follow their demand.
    contacts_follow_a: assert property (@(posedge sys_clk) disable iff (rst)
        !supervision_out && !$past(rst) |-> contact_out == $past(contact_req))
        else $error("contact not following demand");
    // Without a latched fault message the panel shows the requested target.
    target_free_a: assert property (@(posedge sys_clk) disable iff (rst)
        !panel_fault_shown && !$past(rst) |-> panel_target == $past(panel_target_req))
        else $error("panel target not shown");
endmodule : rcss_reclose_supervisor

// ### rcss_pkg.sv
// Package for the reclose event masking and self-supervision block.
// Assumes a 125 MHz single clock and a 32-bit Avalon-MM register slave.
package rcss_pkg;
    // Register byte addresses.
    localparam logic [3:0] RCSS_ADDR_MASK_LOW = 4'h0;
    localparam logic [3:0] RCSS_ADDR_MASK_HIGH = 4'h4;
    localparam logic [3:0] RCSS_ADDR_STATUS = 4'h8;
    localparam logic [3:0] RCSS_ADDR_CONTROL = 4'hc;
    localparam logic [3:0] RCSS_ADDR_EVENT = 4'h0;
    // Mask widths and reset values.
    localparam int RCSS_LOW_W = 12;
    localparam int RCSS_HIGH_W = 10;
    localparam logic [11:0] RCSS_MASK_LOW_RST = 12'h03ff;
    localparam logic [9:0] RCSS_MASK_HIGH_RST = 10'h03f0;
    // Fault codes.
    localparam logic [7:0] RCSS_CODE_NONE = 8'h00;
    localparam logic [7:0] RCSS_CODE_BASE_CONTACT0 = 8'h04;
    localparam logic [7:0] RCSS_CODE_BASE_ENABLE = 8'h09;
    localparam logic [7:0] RCSS_CODE_BASE_FEEDBACK = 8'h0a;
    localparam logic [7:0] RCSS_CODE_OPT_CONTACT0 = 8'h0d;
    localparam logic [7:0] RCSS_CODE_OPT_ENABLE = 8'h10;
    localparam logic [7:0] RCSS_CODE_OPT_FEEDBACK = 8'h11;
    localparam logic [7:0] RCSS_CODE_SUPPLY_DIP = 8'h14;
    localparam logic [7:0] RCSS_CODE_PROGRAM_MEM = 8'h1e;
    localparam logic [7:0] RCSS_CODE_WORK_MEM = 8'h32;
    localparam logic [7:0] RCSS_CODE_PARAM_MEM = 8'h33;
    localparam logic [7:0] RCSS_CODE_CALIB_MEM = 8'h37;
    localparam logic [7:0] RCSS_CODE_IO_MISSING = 8'h50;
    localparam logic [7:0] RCSS_CODE_IO_UNKNOWN = 8'h51;
    localparam logic [7:0] RCSS_CODE_IO_CONFIG = 8'h52;
    localparam logic [7:0] RCSS_CODE_POWER_FAULTY = 8'h55;
    localparam logic [7:0] RCSS_CODE_POWER_UNKNOWN = 8'h56;
    localparam logic [7:0] RCSS_CODE_HW_CONFIG = 8'h5a;
    localparam logic [7:0] RCSS_CODE_COMM_UNKNOWN = 8'h5f;
    localparam logic [7:0] RCSS_CODE_VREF = 8'h83;
    localparam logic [7:0] RCSS_CODE_LIGHT_TWO = 8'hf0;
    localparam logic [7:0] RCSS_CODE_LIGHT_ONE = 8'hf1;
    localparam logic [7:0] RCSS_CODE_MEASURE = 8'hfd;
    // Timing: restart pulse and the wait for recovery, in microseconds.
    localparam int RCSS_CLK_MHZ = 125;
    localparam int RCSS_RESTART_US = 1;
    localparam int RCSS_RESTART_CYC = RCSS_RESTART_US * RCSS_CLK_MHZ;
    localparam int RCSS_RECOVER_US = 100;
    localparam int RCSS_RECOVER_CYC = RCSS_RECOVER_US * RCSS_CLK_MHZ;
    // Flash half period in milliseconds.
    localparam int RCSS_FLASH_MS = 250;
    localparam int RCSS_FLASH_CYC = RCSS_FLASH_MS * 1000 * RCSS_CLK_MHZ;
    // Control bit positions.
    localparam int RCSS_CTL_CLEAR_MSG = 0;
    localparam int RCSS_CTL_CLEAR_EVT = 1;
    // Self-supervision states.
    typedef enum logic [3:0] {
        RCSS_ST_OK = 4'b0001,
        RCSS_ST_RESTART = 4'b0010,
        RCSS_ST_VERIFY = 4'b0100,
        RCSS_ST_FAULT = 4'b1000
    } rcss_state_t;
endpackage : rcss_pkg

// ### rcss_panel_model.sv
// Behavioural operator panel standing at the far side of the supervision block.
// Assumes the bench asks for a clear press through clear_cmd, one cycle long.
`timescale 1ns/1ps
module rcss_panel_model (
    // Clock.
    input wire logic sys_clk,
    // Bench request for an operator press.
    input wire logic clear_cmd,
    // Panel outputs towards the block.
    output logic panel_clear
);
    // The press reaches the block one cycle after the request, as a pulse.
    always_ff @(posedge sys_clk) begin
        panel_clear <= clear_cmd;
    end
endmodule : rcss_panel_model

// ### tb_rcss_reclose_supervisor.sv
// Self-checking bench for the reclose event masks and self-supervision sequencer.
// Assumes RECOVER_CYC 4 and FLASH_CYC 3 so that a fault sequence stays short.
`timescale 1ns/1ps
module tb_rcss_reclose_supervisor;
    import rcss_pkg::*;
    logic sys_clk = 0, rst = 1, avs_read = 0, avs_write = 0, clear_cmd = 0, panel_clear;
    logic [3:0] avs_address = 0, avs_byteenable = 4'h3;
    logic [31:0] avs_writedata = 0, avs_readdata, rd;
    logic avs_waitrequest, supervision_out, ready_led, restart_req, panel_fault_shown;
    logic [11:0] evt_low = 0;
    logic [9:0] evt_high = 0;
    logic [27:0] flt_v = 0;
    logic [7:0] contact_req = 0, panel_target_req = 0, contact_out, panel_code, panel_target;
    logic [15:0] lfsr_st = 16'h0051;
    int miscompares = 0, samples_checked = 0, mask_lo, mask_hi, exp_ev, tog, n;
    int codes[28] = '{4, 5, 6, 7, 8, 9, 10, 13, 14, 15, 16, 17, 20, 30, 50, 51, 55,
                      80, 81, 82, 85, 86, 90, 95, 131, 241, 240, 253};
    // Half period of 4 ns gives the 125 MHz clock.
    always #4 sys_clk = ~sys_clk;
    rcss_reclose_supervisor #(.RECOVER_CYC(4), .FLASH_CYC(3))
        i_rcss_reclose_supervisor (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .evt_low(evt_low), .evt_high(evt_high),
        .flt_base_contact(flt_v[4:0]), .flt_base_enable(flt_v[5]),
        .flt_base_feedback(flt_v[6]), .flt_opt_contact(flt_v[9:7]),
        .flt_opt_enable(flt_v[10]), .flt_opt_feedback(flt_v[11]),
        .flt_supply_dip(flt_v[12]), .flt_program_mem(flt_v[13]), .flt_work_mem(flt_v[14]),
        .flt_param_mem(flt_v[15]), .flt_calib_mem(flt_v[16]), .flt_io_module(flt_v[19:17]),
        .flt_power_module(flt_v[21:20]), .flt_hw_config(flt_v[22]),
        .flt_comm_unknown(flt_v[23]), .flt_vref(flt_v[24]), .flt_light_sensor(flt_v[26:25]),
        .flt_measure(flt_v[27]), .contact_req(contact_req), .panel_target_req(panel_target_req),
        .panel_clear(panel_clear), .contact_out(contact_out), .supervision_out(supervision_out),
        .ready_led(ready_led), .restart_req(restart_req), .panel_code(panel_code),
        .panel_fault_shown(panel_fault_shown), .panel_target(panel_target));
    rcss_panel_model i_rcss_panel_model (.sys_clk(sys_clk), .clear_cmd(clear_cmd),
        .panel_clear(panel_clear));
    // Pseudo-random source for masks and contact demands.
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    // Prints the counts and the verdict, then stops the run.
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : complete_run
    // Compares a seen value with the expected one and counts the result.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One Avalon access; the request holds until waitrequest is seen low at a rising edge.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (n == 50) begin
            miscompares++;
            complete_run();
        end
        rd = avs_readdata;
        avs_write <= 0;
        avs_read <= 0;
    endtask : bus
    // Waits a bounded time for supervision_out to reach a level.
    task automatic wait_sup(input logic lvl);
        for (n = 0; n < 400 && supervision_out !== lvl; n++) @(negedge sys_clk);
        if (n == 400) begin
            miscompares++;
            complete_run();
        end
        @(posedge sys_clk);
    endtask : wait_sup
    // Main sequence: reset values, masking, then every fault source in turn.
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 0;
        @(posedge sys_clk);
        bus(0, RCSS_ADDR_MASK_LOW, 0);
        check(rd, 32'h0000_03ff);
        bus(0, RCSS_ADDR_MASK_HIGH, 0);
        check(rd, 32'd1008);
        bus(1, 4'h2, 32'hffff_ffff);
        bus(0, 4'h2, 0);
        check(rd, 0);
        for (int k = 0; k < 2; k++) begin
            lfsr_st = lfsr_next(lfsr_next(lfsr_st));
            mask_lo = (k == 0) ? 'h3ff : lfsr_st[11:0];
            mask_hi = (k == 0) ? 'h3f0 : lfsr_st[15:6];
            bus(1, RCSS_ADDR_MASK_LOW, mask_lo);
            bus(1, RCSS_ADDR_MASK_HIGH, mask_hi);
            for (int i = 0; i < 22; i++) begin
                exp_ev = ((mask_hi << 12) | mask_lo) & (1 << i);
                {evt_high, evt_low} <= 22'(1) << i;
                @(posedge sys_clk);
                {evt_high, evt_low} <= '0;
                bus(0, RCSS_ADDR_CONTROL, 0);
                check(rd, exp_ev);
                bus(1, RCSS_ADDR_CONTROL, 32'h0000_0002);
            end
        end
        for (int f = 0; f < 28; f++) begin
            @(posedge sys_clk);
            lfsr_st = lfsr_next(lfsr_st);
            contact_req <= lfsr_st[7:0];
            panel_target_req <= lfsr_st[15:8];
            flt_v <= 28'(1) << f;
            for (n = 0; n < 20 && restart_req !== 1'b1; n++) @(negedge sys_clk);
            check(restart_req & ~supervision_out, 1);
            wait_sup(1);
            @(negedge sys_clk);
            check(contact_out, 0);
            check({panel_fault_shown, panel_code}, {1'b1, 8'(codes[f])});
            check(panel_target, codes[f]);
            tog = 0;
            for (int c = 0; c < 8; c++) begin
                rd[0] = ready_led;
                @(negedge sys_clk);
                if (ready_led !== rd[0]) tog++;
            end
            check(tog >= 2, 1);
            bus(0, RCSS_ADDR_STATUS, 0);
            check({rd[15:8], rd[4], rd[3:0]}, {8'(codes[f]), 1'b1, RCSS_ST_FAULT});
            bus(0, RCSS_ADDR_MASK_LOW, 0);
            check(rd, (f == 15) ? 0 : mask_lo);
            clear_cmd <= 1;
            @(posedge sys_clk);
            clear_cmd <= 0;
            bus(1, RCSS_ADDR_CONTROL, 32'h0000_0001);
            flt_v <= '0;
            @(negedge sys_clk);
            check(panel_fault_shown, 1);
            wait_sup(0);
            repeat (2) @(posedge sys_clk);
            @(negedge sys_clk);
            check({contact_out, panel_fault_shown, ready_led}, {contact_req, 1'b1, 1'b1});
            bus(1, RCSS_ADDR_CONTROL, 32'h0000_0001);
            @(negedge sys_clk);
            check({panel_fault_shown, panel_target}, {1'b0, panel_target_req});
        end
        complete_run();
    end
endmodule : tb_rcss_reclose_supervisor
